/* File: core/cslp_consts.svh */
/*
 * Timing counts, header layout and option fields of the configuration loader.
 * Assumes a 40 MHz system clock on both ends.
 */
`ifndef CSLP_CONSTS_SVH
`define CSLP_CONSTS_SVH

`define CSLP_SYS_MHZ       40
`define CSLP_CONFIG_CLOCK_NS       200
`define CSLP_DIV           ((`CSLP_CONFIG_CLOCK_NS * `CSLP_SYS_MHZ) / 1000)
`define CSLP_STROBE_NS     100
`define CSLP_STROBE_CYC    ((`CSLP_STROBE_NS * `CSLP_SYS_MHZ + 999) / 1000)
`define CSLP_INIT_WAIT     8'h20
`define CSLP_MODE_DELAY    8'h02
`define CSLP_FIRST_EDGE    2
`define CSLP_BYTE_EDGES    8
// three internal rises: two could end busy after barely 1.6 periods
`define CSLP_BUSY_MIN      2'h3
`define CSLP_PREAMBLE      4'h2
`define CSLP_HDR_BYTES     3'h5
`define CSLP_HDR_OPT       3'h4
`define CSLP_SIGNAL_ACCESS_A_END   2'h3
`define CSLP_EXTRA_CLKS    4'h8
`define CSLP_OPT_DONE      1:0
`define CSLP_OPT_GSR       3:2
`define CSLP_OPT_IO        5:4

`endif

/* File: core/cslp_pkg.sv */
/*
 * Types and the shared synchroniser helper of the configuration loader.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package cslp_pkg;

    typedef enum logic {
        CSLP_ASYNC = 1'b0,
        CSLP_SYNC  = 1'b1
    } cslp_mode_t;

    typedef enum logic [4:0] {
        ST_INIT  = 5'h01,
        ST_MODE  = 5'h02,
        ST_LOAD  = 5'h04,
        ST_START = 5'h08,
        ST_USER  = 5'h10
    } cslp_dev_state_t;

    typedef enum logic [6:0] {
        H_IDLE  = 7'h01,
        H_WINIT = 7'h02,
        H_SYNC  = 7'h04,
        H_AWAIT = 7'h08,
        H_ASTRB = 7'h10,
        H_FLUSH = 7'h20,
        H_FIN   = 7'h40
    } cslp_host_state_t;

    // level only moves once the second and third stage agree
    function automatic logic agree(input logic lv, input logic s2, input logic s3);
        return (s2 == s3) ? s2 : lv;
    endfunction

endpackage

`default_nettype wire

/* File: core/cslp_if.sv */
/*
 * Pins between configuring host and the loading device.
 * Assumes the bench instances it and joins both ends to it.
 */
`default_nettype none

interface cslp_if;
    logic       config_clock;
    logic [7:0] parallel_config_byte;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       select_active_low;
    logic       select_active_high;
    logic       mode_sel;
    logic       host_init_oe;
    logic       dev_init_oe;
    logic       init_status;
    logic       rdy_busy;
    logic       serial_out;
    logic       done;

    // open-drain init line: either end may only pull it low
    assign init_status = ~(host_init_oe | dev_init_oe);

    modport device (
        input  config_clock, parallel_config_byte, write_strobe_n, read_strobe_n,
        input  select_active_low, select_active_high, mode_sel, init_status,
        output dev_init_oe, rdy_busy, serial_out, done
    );

    modport host (
        output config_clock, parallel_config_byte, write_strobe_n, read_strobe_n,
        output select_active_low, select_active_high, mode_sel, host_init_oe,
        input  init_status, dev_init_oe, rdy_busy, serial_out, done
    );
endinterface

`default_nettype wire

/* File: core/cslp_host.sv */
/*
 * Host end: feeds configuration bytes in synchronous or asynchronous
 * peripheral mode. Assumes device pins come from another chip.
 */
`include "cslp_consts.svh"
`default_nettype none

module cslp_host
    import cslp_pkg::*;
(
    input  wire logic       SYS_CLK,   // 40 MHz clock
    input  wire logic       NRST,      // synchronous reset, active low
    cslp_if.host            LINK,      // pins toward the device
    input  wire logic       START,     // begin a load
    input  wire logic       MODE_SEL,  // 1 sync, 0 async
    input  wire logic       HOLD_INIT, // keep init line low
    input  wire logic [7:0] IN_DATA,   // next byte
    input  wire logic       IN_VALID,  // byte present
    input  wire logic       IN_LAST,   // byte is the last
    output logic            IN_READY,  // byte taken
    output logic            BUSY,      // load in progress
    output logic            FINISHED   // device reported done
);
    localparam logic [3:0] DIV_LAST = 4'(`CSLP_DIV - 1);
    localparam logic [3:0] HALF     = 4'(`CSLP_DIV / 2);
    localparam logic [3:0] STB_LAST = 4'(`CSLP_STROBE_CYC - 1);
    localparam logic [2:0] CAD_INIT = 3'(`CSLP_BYTE_EDGES - `CSLP_FIRST_EDGE);

    cslp_host_state_t state_r, state_nxt;
    logic [2:0] s1_r, s2_r, s3_r, lv_r, lv_nxt;
    logic [3:0] cnt_r, cnt_nxt, hi_r, hi_nxt, tmr_r, tmr_nxt, extra_r, extra_nxt;
    logic [2:0] cad_r, cad_nxt;
    logic [7:0] data_r, data_nxt;
    logic       config_clock_r, config_clock_nxt, have_r, have_nxt, last_r, last_nxt;
    logic       ws_n_r, ws_n_nxt, cs_r, cs_nxt, seen_r, seen_nxt, mode_r, mode_nxt;
    logic       hinit_r, rise, take;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            lv_nxt[i] = agree(lv_r[i], s2_r[i], s3_r[i]);
        end
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        hi_nxt    = hi_r;
        tmr_nxt   = tmr_r;
        extra_nxt = extra_r;
        cad_nxt   = cad_r;
        data_nxt  = data_r;
        config_clock_nxt  = config_clock_r;
        have_nxt  = have_r;
        last_nxt  = last_r;
        ws_n_nxt  = ws_n_r;
        cs_nxt    = cs_r;
        seen_nxt  = seen_r;
        mode_nxt  = mode_r;
        take      = 1'b0;
        rise      = 1'b0;
        unique case (state_r)
            H_IDLE, H_FIN: begin
                if (START) begin
                    mode_nxt  = MODE_SEL;
                    state_nxt = H_WINIT;
                    last_nxt  = 1'b0;
                    have_nxt  = 1'b0;
                end
            end
            H_WINIT: begin
                if (lv_r[0]) begin
                    cnt_nxt   = HALF;
                    cad_nxt   = CAD_INIT;
                    hi_nxt    = 4'h0;
                    seen_nxt  = 1'b1;
                    state_nxt = mode_r ? H_SYNC : H_AWAIT;
                end
            end
            H_SYNC, H_FLUSH: begin
                if (mode_r) begin
                    // clock stalls low while the next byte is missing
                    if (!(cnt_r == DIV_LAST && !have_r && !last_r && state_r == H_SYNC)) begin
                        cnt_nxt = (cnt_r == DIV_LAST) ? 4'h0 : cnt_r + 4'h1;
                    end
                    rise     = (cnt_r == DIV_LAST) && (cnt_nxt == 4'h0);
                    config_clock_nxt = (cnt_nxt < HALF);
                    if (rise) begin
                        cad_nxt = cad_r + 3'h1;
                        if (cad_nxt == 3'h0) begin
                            have_nxt = 1'b0;
                        end
                    end
                    if (state_r == H_SYNC && !have_r && !last_r && cnt_r >= HALF && IN_VALID) begin
                        take     = 1'b1;
                        data_nxt = IN_DATA;
                        have_nxt = 1'b1;
                        last_nxt = IN_LAST;
                    end
                    if (state_r == H_SYNC && last_r && !have_r) begin
                        state_nxt = H_FLUSH;
                        extra_nxt = 4'h0;
                    end
                    if (state_r == H_FLUSH && rise && lv_r[2]) begin
                        extra_nxt = extra_r + 4'h1;
                        if (extra_r == `CSLP_EXTRA_CLKS) begin
                            state_nxt = H_FIN;
                            config_clock_nxt  = 1'b0;
                        end
                    end
                end else if (lv_r[2]) begin
                    state_nxt = H_FIN;
                end
            end
            H_AWAIT: begin
                if (!lv_r[1]) begin
                    hi_nxt   = 4'h0;
                    seen_nxt = 1'b1;
                end else if (seen_r && hi_r != 4'(`CSLP_DIV)) begin
                    hi_nxt = hi_r + 4'h1;
                end
                // ready must have stood for a whole config clock period
                if (seen_r && hi_r == 4'(`CSLP_DIV)) begin
                    if (last_r) begin
                        state_nxt = H_FLUSH;
                    end else if (IN_VALID) begin
                        take      = 1'b1;
                        data_nxt  = IN_DATA;
                        last_nxt  = IN_LAST;
                        ws_n_nxt  = 1'b0;
                        cs_nxt    = 1'b1;
                        tmr_nxt   = 4'h0;
                        seen_nxt  = 1'b0;
                        state_nxt = H_ASTRB;
                    end
                end
            end
            H_ASTRB: begin
                tmr_nxt = tmr_r + 4'h1;
                if (tmr_r == STB_LAST) begin
                    ws_n_nxt  = 1'b1;
                    cs_nxt    = 1'b0;
                    hi_nxt    = 4'h0;
                    state_nxt = H_AWAIT;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_r <= H_IDLE;
            {s1_r, s2_r, s3_r, lv_r} <= 12'h000;
            {cnt_r, hi_r, tmr_r, extra_r} <= 16'h0000;
            cad_r   <= 3'h0;
            data_r  <= 8'h00;
            {config_clock_r, have_r, last_r, cs_r, seen_r, mode_r, hinit_r} <= 7'h00;
            ws_n_r  <= 1'b1;
        end else begin
            s1_r    <= {LINK.done, LINK.rdy_busy, LINK.init_status};
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            lv_r    <= lv_nxt;
            state_r <= state_nxt;
            {cnt_r, hi_r, tmr_r, extra_r} <= {cnt_nxt, hi_nxt, tmr_nxt, extra_nxt};
            cad_r   <= cad_nxt;
            data_r  <= data_nxt;
            {config_clock_r, have_r, last_r, cs_r, seen_r, mode_r} <=
                {config_clock_nxt, have_nxt, last_nxt, cs_nxt, seen_nxt, mode_nxt};
            ws_n_r  <= ws_n_nxt;
            hinit_r <= HOLD_INIT;
        end
    end

    assign LINK.config_clock         = config_clock_r;
    assign LINK.parallel_config_byte = data_r;
    assign LINK.write_strobe_n       = ws_n_r;
    assign LINK.read_strobe_n        = 1'b1;
    assign LINK.select_active_low    = ~cs_r;
    assign LINK.select_active_high   = cs_r;
    assign LINK.mode_sel             = mode_r;
    assign LINK.host_init_oe         = hinit_r;
    assign IN_READY                  = take;
    assign BUSY     = (state_r != H_IDLE) && (state_r != H_FIN);
    assign FINISHED = (state_r == H_FIN);
endmodule

`default_nettype wire

/* File: core/cslp_device.sv */
/*
 * Device end: peripheral-mode byte loader, double-buffered serialiser and
 * start-up sequencer. Assumes host pins arrive from another chip.
 */
`include "cslp_consts.svh"
`default_nettype none

// Behaviour
// - start-up ends by selecting the user clock
// - user outputs enabled only at I/O event
// - three start-up events in any order
// - sync mode uses host-supplied config clock
// - first byte on second rising edge
// - later bytes every eighth rising edge
// - acknowledge high one period after capture
// - serial shifting starts half period after load in sync, in async at the first fall after the third rise that finds the shifter empty
// - host gives extra clocks after last byte
// - host waits for init high first
// - async busy lasts two to nine periods
// - busy while converter cannot take byte
// - busy shortest empty, longest both levels full
// - write-to-processing delay depends on converter, phase
// - data latched before write strobe rises
// - host holds strobe until ready stood
// - mode sampled two clocks after init high
// - preamble 0010 announces 24-bit length count
module cslp_device
    import cslp_pkg::*;
(
    input  wire logic SYS_CLK,      // 40 MHz clock
    input  wire logic NRST,         // synchronous reset, active low
    cslp_if.device    LINK,         // pins toward the host
    output logic      DONE,         // done flag
    output logic      GSR_ACTIVE,   // global set/reset held
    output logic      USER_IO_EN,   // user outputs enabled
    output logic      USER_CLK_SEL, // user clock selected
    output logic      CFG_ERROR     // bad preamble seen
);
    localparam logic [3:0] DIV_LAST = 4'(`CSLP_DIV - 1);
    localparam logic [3:0] HALF     = 4'(`CSLP_DIV / 2);
    localparam logic [2:0] CAD_INIT = 3'(`CSLP_BYTE_EDGES - `CSLP_FIRST_EDGE);

    // slot 3 folds onto slot 2, so nothing fires after the end of start-up
    function automatic logic fires(input logic [1:0] slot, input logic [1:0] cnt);
        return cnt > ((slot == 2'h3) ? 2'h2 : slot);
    endfunction

    // synchroniser group
    logic [2:0] clk_s_r, ws_s_r, init_s_r, mode_s_r;
    logic [7:0] d1_r, d2_r, d3_r, data_lv_r, data_lv_nxt;
    logic       clk_lv_r, ws_lv_r, init_lv_r, mode_lv_r;
    logic       clk_lv_nxt, ws_lv_nxt, init_lv_nxt, mode_lv_nxt;
    logic       ws_pin;

    // a write needs strobe and both selects, read strobe idle
    assign ws_pin = ~LINK.write_strobe_n & ~LINK.select_active_low
                  & LINK.select_active_high & LINK.read_strobe_n;

    always_comb begin
        clk_lv_nxt  = agree(clk_lv_r, clk_s_r[1], clk_s_r[2]);
        ws_lv_nxt   = agree(ws_lv_r, ws_s_r[1], ws_s_r[2]);
        init_lv_nxt = agree(init_lv_r, init_s_r[1], init_s_r[2]);
        mode_lv_nxt = agree(mode_lv_r, mode_s_r[1], mode_s_r[2]);
        data_lv_nxt = (d2_r == d3_r) ? d2_r : data_lv_r;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            {clk_s_r, ws_s_r, init_s_r, mode_s_r} <= 12'h000;
            {d1_r, d2_r, d3_r, data_lv_r} <= 32'h0000_0000;
            {clk_lv_r, ws_lv_r, init_lv_r, mode_lv_r} <= 4'h0;
        end else begin
            clk_s_r   <= {clk_s_r[1:0], LINK.config_clock};
            ws_s_r    <= {ws_s_r[1:0], ws_pin};
            init_s_r  <= {init_s_r[1:0], LINK.init_status};
            mode_s_r  <= {mode_s_r[1:0], LINK.mode_sel};
            d1_r      <= LINK.parallel_config_byte;
            d2_r      <= d1_r;
            d3_r      <= d2_r;
            clk_lv_r  <= clk_lv_nxt;
            ws_lv_r   <= ws_lv_nxt;
            init_lv_r <= init_lv_nxt;
            mode_lv_r <= mode_lv_nxt;
            data_lv_r <= data_lv_nxt;
        end
    end

    // loader and start-up group
    cslp_dev_state_t state_r, state_nxt;
    cslp_mode_t      mode_r, mode_nxt;
    logic [7:0]  wait_r, wait_nxt, hold_r, hold_nxt, shift_r, shift_nxt, lat_r, lat_nxt;
    logic [3:0]  div_r, div_nxt, scnt_r, scnt_nxt;
    logic [2:0]  cad_r, cad_nxt, hdr_r, hdr_nxt;
    logic [1:0]  busy_r, busy_nxt, start_r, start_nxt;
    logic [23:0] len_r, len_nxt, bits_r, bits_nxt;
    logic [5:0]  opt_r, opt_nxt;
    logic        full_r, full_nxt, ack_r, ack_nxt, dout_r, dout_nxt;
    logic        ioe_r, ioe_nxt, err_r, err_nxt;
    logic        done_r, done_nxt, gsr_r, gsr_nxt, io_r, io_nxt, uclk_r, uclk_nxt;
    logic        rise, fall, accept, sync_m;
    logic [7:0]  acc_byte;

    always_comb begin
        sync_m    = (mode_r == CSLP_SYNC);
        div_nxt   = (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
        // async mode times itself from an internal divider
        rise      = sync_m ? (clk_lv_nxt & ~clk_lv_r) : (div_r == 4'h0);
        fall      = sync_m ? (~clk_lv_nxt & clk_lv_r) : (div_r == HALF);
        state_nxt = state_r;
        mode_nxt  = mode_r;
        wait_nxt  = wait_r;
        hold_nxt  = hold_r;
        shift_nxt = shift_r;
        lat_nxt   = lat_r;
        scnt_nxt  = scnt_r;
        cad_nxt   = cad_r;
        hdr_nxt   = hdr_r;
        busy_nxt  = busy_r;
        start_nxt = start_r;
        len_nxt   = len_r;
        bits_nxt  = bits_r;
        opt_nxt   = opt_r;
        full_nxt  = full_r;
        ack_nxt   = ack_r;
        dout_nxt  = dout_r;
        ioe_nxt   = ioe_r;
        err_nxt   = err_r;
        done_nxt  = done_r;
        gsr_nxt   = gsr_r;
        io_nxt    = io_r;
        uclk_nxt  = uclk_r;
        accept    = 1'b0;
        acc_byte  = data_lv_r;
        unique case (state_r)
            ST_INIT: begin
                ioe_nxt = 1'b1;
                if (wait_r != `CSLP_INIT_WAIT) begin
                    wait_nxt = wait_r + 8'h01;
                end else begin
                    ioe_nxt = 1'b0;
                    if (init_lv_r) begin
                        state_nxt = ST_MODE;
                        wait_nxt  = 8'h00;
                    end
                end
            end
            ST_MODE: begin
                if (wait_r == `CSLP_MODE_DELAY - 8'h01) begin
                    mode_nxt  = cslp_mode_t'(mode_lv_r);
                    cad_nxt   = CAD_INIT;
                    state_nxt = ST_LOAD;
                end else begin
                    wait_nxt = wait_r + 8'h01;
                end
            end
            ST_LOAD: begin
                if (sync_m) begin
                    if (rise) begin
                        cad_nxt = cad_r + 3'h1;
                        ack_nxt = 1'b0;
                        if (cad_nxt == 3'h0 && !err_r) begin
                            accept  = 1'b1;
                            ack_nxt = 1'b1;
                        end
                    end
                end else begin
                    if (ws_lv_r) begin
                        lat_nxt = data_lv_r;
                    end
                    // strobe end while full is dropped; host waits for ready
                    if (ws_lv_r && !ws_lv_nxt && !full_r && !err_r) begin
                        accept   = 1'b1;
                        acc_byte = lat_r;
                    end
                end
                if (rise && full_r && busy_r != `CSLP_BUSY_MIN) begin
                    busy_nxt = busy_r + 2'h1;
                end
                if (fall) begin
                    if (scnt_r != 4'h0) begin
                        dout_nxt  = shift_r[7];
                        shift_nxt = {shift_r[6:0], 1'b0};
                        scnt_nxt  = scnt_r - 4'h1;
                        bits_nxt  = bits_r + 24'h1;
                    end else if (full_r && (sync_m || busy_r == `CSLP_BUSY_MIN)) begin
                        // first bit leaves on the falling edge after the load in sync, in async on the first fall after the third rise with the shifter empty
                        dout_nxt  = hold_r[7];
                        shift_nxt = {hold_r[6:0], 1'b0};
                        scnt_nxt  = 4'h7;
                        full_nxt  = 1'b0;
                        bits_nxt  = bits_r + 24'h1;
                    end
                end
                if (accept) begin
                    hold_nxt = acc_byte;
                    full_nxt = 1'b1;
                    busy_nxt = 2'h0;
                    if (hdr_r == 3'h0 && acc_byte[3:0] != `CSLP_PREAMBLE) begin
                        err_nxt = 1'b1;
                        ioe_nxt = 1'b1;
                    end
                    if (hdr_r != 3'h0 && hdr_r < `CSLP_HDR_OPT) begin
                        len_nxt = {len_r[15:0], acc_byte};
                    end
                    if (hdr_r == `CSLP_HDR_OPT) begin
                        opt_nxt = acc_byte[5:0];
                    end
                    if (hdr_r != `CSLP_HDR_BYTES) begin
                        hdr_nxt = hdr_r + 3'h1;
                    end
                end
                if (hdr_r == `CSLP_HDR_BYTES && bits_nxt == len_r && scnt_nxt == 4'h0) begin
                    state_nxt = ST_START;
                    start_nxt = 2'h0;
                end
            end
            ST_START: begin
                if (rise) begin
                    start_nxt = start_r + 2'h1;
                    done_nxt  = fires(opt_r[`CSLP_OPT_DONE], start_nxt);
                    gsr_nxt   = ~fires(opt_r[`CSLP_OPT_GSR], start_nxt);
                    io_nxt    = fires(opt_r[`CSLP_OPT_IO], start_nxt);
                    if (start_nxt == `CSLP_SIGNAL_ACCESS_A_END) begin
                        uclk_nxt  = 1'b1;
                        state_nxt = ST_USER;
                    end
                end
            end
            ST_USER: begin
                uclk_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_r <= ST_INIT;
            mode_r  <= CSLP_ASYNC;
            {wait_r, hold_r, shift_r, lat_r} <= 32'h0000_0000;
            {div_r, scnt_r} <= 8'h00;
            {cad_r, hdr_r}  <= 6'h00;
            {busy_r, start_r} <= 4'h0;
            {len_r, bits_r} <= 48'h0000_0000_0000;
            opt_r   <= 6'h00;
            {full_r, ack_r, dout_r, err_r, done_r, io_r, uclk_r} <= 7'h00;
            ioe_r   <= 1'b1;
            gsr_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            mode_r  <= mode_nxt;
            {wait_r, hold_r, shift_r, lat_r} <= {wait_nxt, hold_nxt, shift_nxt, lat_nxt};
            {div_r, scnt_r} <= {div_nxt, scnt_nxt};
            {cad_r, hdr_r}  <= {cad_nxt, hdr_nxt};
            {busy_r, start_r} <= {busy_nxt, start_nxt};
            {len_r, bits_r} <= {len_nxt, bits_nxt};
            opt_r   <= opt_nxt;
            {full_r, ack_r, dout_r, err_r, done_r, io_r, uclk_r} <=
                {full_nxt, ack_nxt, dout_nxt, err_nxt, done_nxt, io_nxt, uclk_nxt};
            ioe_r   <= ioe_nxt;
            gsr_r   <= gsr_nxt;
        end
    end

    // sync: acknowledge pulse; async: ready while the input level is free
    assign LINK.rdy_busy    = (state_r == ST_LOAD) && (sync_m ? ack_r : ~full_r);
    assign LINK.serial_out  = dout_r;
    assign LINK.dev_init_oe = ioe_r;
    assign LINK.done        = done_r;
    assign DONE             = done_r;
    assign GSR_ACTIVE       = gsr_r;
    assign USER_IO_EN       = io_r;
    assign USER_CLK_SEL     = uclk_r;
    assign CFG_ERROR        = err_r;
endmodule

`default_nettype wire

/* File: sim/cslp_props.sv */
/* Timing checks on the host-to-device pins.
   Assumes the bench hands in the interface signals and the domain clock. */
`default_nettype none
module cslp_props (
    input wire logic SYS_CLK,        // system clock
    input wire logic NRST,           // sync reset, active low
    input wire logic mode_sel,       // 1 sync, 0 async
    input wire logic init_status,    // resolved init line
    input wire logic rdy_busy,       // ready/busy or ack
    input wire logic write_strobe_n, // write strobe
    input wire logic done            // done flag
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    a_init_wait: assert property ($rose(NRST) |-> !init_status[*8])
        else $error("init released too early");
    a_ack_needs_init: assert property ($rose(rdy_busy) |-> $past(init_status))
        else $error("ready before init high");
    a_ack_one_period: assert property ($rose(rdy_busy) && mode_sel
        |-> rdy_busy[*8] ##1 !rdy_busy) else $error("ack width wrong");
    a_busy_min_span: assert property ($fell(rdy_busy) && !mode_sel
        |-> !rdy_busy[*8] ##1 !rdy_busy[*8]) else $error("busy too short");
    a_busy_after_write: assert property ($rose(write_strobe_n) && !mode_sel
        |-> ##[1:10] !rdy_busy) else $error("no busy after write");
    a_strobe_width: assert property ($fell(write_strobe_n)
        |-> !write_strobe_n[*4] ##1 write_strobe_n) else $error("strobe width wrong");
    a_strobe_on_ready: assert property ($fell(write_strobe_n) |-> rdy_busy)
        else $error("write while busy");
    a_done_holds: assert property (done |=> done)
        else $error("done dropped");
    c_done: cover property ($rose(done));
    c_write: cover property ($fell(write_strobe_n));
    c_ack: cover property ($rose(rdy_busy) && mode_sel);
endmodule
`default_nettype wire

/* File: sim/config_signal_access_a_peripheral_load_bench.sv */
/* Loads both ends through one link in each mode, then a bad preamble.
   Assumes the host end makes the link clock from its own divider. */
`default_nettype none
module config_signal_access_a_peripheral_load_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic m; logic [7:0] opt; logic gsr_d; logic io_d;} cslp_row_t;
    logic       sys_clk = 1'b0, nrst = 1'b0, start = 1'b0, mode = 1'b0, hold_init = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic       in_valid = 1'b0, in_last = 1'b0;
    logic       in_ready, busy, finished, done_o, gsr, io_en, clk_sel, cfg_err;
    int         n_errors = 0, compares = 0;
    logic [7:0] bytes [7];
    // rows: done slot 0 then gsr then io; and io/gsr ahead of done
    cslp_row_t  rows [2] = '{'{1'b1, 8'h24, 1'b1, 1'b0}, '{1'b0, 8'h01, 1'b0, 1'b1}};
    cslp_if link ();
    cslp_host i_cslp_host (.SYS_CLK(sys_clk), .NRST(nrst), .LINK(link), .START(start),
        .MODE_SEL(mode), .HOLD_INIT(hold_init), .IN_DATA(in_data), .IN_VALID(in_valid),
        .IN_LAST(in_last), .IN_READY(in_ready), .BUSY(busy), .FINISHED(finished));
    cslp_device i_cslp_device (.SYS_CLK(sys_clk), .NRST(nrst), .LINK(link), .DONE(done_o),
        .GSR_ACTIVE(gsr), .USER_IO_EN(io_en), .USER_CLK_SEL(clk_sel), .CFG_ERROR(cfg_err));
    cslp_props i_cslp_props (.SYS_CLK(sys_clk), .NRST(nrst), .mode_sel(link.mode_sel),
        .init_status(link.init_status), .rdy_busy(link.rdy_busy),
        .write_strobe_n(link.write_strobe_n), .done(link.done));
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic reset_dut();
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask
    // bounded wait; a timeout shows up as a handshake mismatch
    task automatic wait_for(ref logic sig);
        int t = 0;
        do @(posedge sys_clk); while (sig !== 1'b1 && ++t < 3000);
        chk("handshake", 1'b1, sig);
    endtask
    task automatic load(input logic m, input int n);
        @(posedge sys_clk);
        start <= 1'b1;
        mode <= m;
        @(posedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            in_data <= bytes[i];
            in_valid <= 1'b1;
            in_last <= (i == n - 1);
            wait_for(in_ready);
        end
        in_valid <= 1'b0;
    endtask
    initial begin
        reset_dut();
        chk("gsr in reset", 1'b1, gsr);
        chk("io in reset", 1'b0, io_en);
        // host holds init low after its start; no clock may run meanwhile
        hold_init <= 1'b1;
        mode <= rows[0].m;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (60) @(posedge sys_clk);
        chk("init held", 1'b0, link.init_status);
        chk("clock held", 1'b0, link.config_clock);
        hold_init <= 1'b0;
        foreach (rows[r]) begin
            // length count is 7 bytes of 8 bits
            bytes = '{8'hf2, 8'h00, 8'h00, 8'h38, rows[r].opt, 8'ha5, 8'h3c};
            load(rows[r].m, 7);
            wait_for(done_o);
            chk("host busy", 1'b1, busy);
            chk("gsr at done", rows[r].gsr_d, gsr);
            chk("io at done", rows[r].io_d, io_en);
            wait_for(finished);
            chk("host idle", 1'b0, busy);
            // async start-up runs on after the host has stopped
            repeat (24) @(posedge sys_clk);
            chk("user clock", 1'b1, clk_sel);
            chk("io enabled", 1'b1, io_en);
            chk("gsr released", 1'b0, gsr);
            reset_dut();
        end
        bytes[0] = 8'h05;
        load(1'b1, 1);
        repeat (300) @(posedge sys_clk);
        chk("preamble fault", 1'b1, cfg_err);
        chk("init pulled", 1'b0, link.init_status);
        chk("no done", 1'b0, done_o);
        chk("serial tail", 1'b1, link.serial_out);
        wrap_up();
    end
    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
